/* hdl/obp_device.sv */
`timescale 1ns/10ps
`default_nettype none
`include "obp_consts.svh"
module obp_device
  import obp_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Link to the controller.
  obp_link_if.dev          lk,
  // Measurement side.
  input  wire logic        meas_valid_i,
  input  wire logic [31:0] meas_data_i,
  input  wire logic        acq_wr_i,
  input  wire logic [8:0]  acq_loc_i,
  input  wire logic [31:0] acq_data_i,
  input  wire obp_word_t   acq_volt_i,
  input  wire logic        acq_fast_i,
  input  wire logic        one_shot_i,
  input  wire logic        bias_ext_i,
  input  wire obp_word_t   full_scale_i,
  // Settings in force.
  output logic [2:0]       out_sel_o,
  output logic             model_o,
  output obp_word_t        normalising_capacitance_o,
  output logic [1:0]       src_o,
  output logic [2:0]       plot_type_o,
  output logic             grid_o,
  output logic             plot_buf_o,
  output logic [1:0]       pen_o,
  output logic [2:0]       line_o,
  output logic [1:0]       label_o,
  output obp_word_t        x_min_o,
  output obp_word_t        x_max_o,
  output obp_word_t        y_min_o,
  output obp_word_t        y_max_o,
  output logic             plot_go_o,
  output logic             grid_go_o,
  output logic             busy_o
);
  typedef struct packed {
    obp_state_e  st;
    logic [2:0]  out_sel;
    logic        model;
    obp_word_t   ncap;
    obp_src_e    src;
    logic [8:0]  first;
    logic [8:0]  last;
    logic [2:0]  ptype;
    logic        grid;
    logic        pbuf;
    logic [1:0]  pen;
    logic [2:0]  line;
    logic [1:0]  label;
    logic        xprog;
    logic        yprog;
    obp_word_t   xmin;
    obp_word_t   xmax;
    obp_word_t   ymin;
    obp_word_t   ymax;
    logic [31:0] last_rd;
    logic        rd_ok;
    logic [8:0]  loc;
    logic [8:0]  end_loc;
    logic        from_b;
    logic        plot_pend;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        rd_last;
    logic        done;
    logic        err;
    logic        plot_go;
    logic        grid_go;
    logic        a_par;
    logic        a_fast;
    logic        b_fast;
    logic        a_any;
    obp_word_t   amin;
    obp_word_t   amax;
    obp_word_t   bmin;
    obp_word_t   bmax;
    logic [450:1] val_a;
    logic [450:1] val_b;
  } obp_dev_s;

  obp_dev_s    s_ff;
  obp_dev_s    nxt_s;
  logic [31:0] mem_a [1:450];
  logic [31:0] mem_b [1:450];

  function automatic logic obp_in(input obp_word_t v, input obp_word_t lo, input obp_word_t hi);
    obp_in = (v >= lo) && (v <= hi);
  endfunction : obp_in

  function automatic logic obp_loc_ok(input obp_word_t v);
    obp_loc_ok = obp_in(v, 32'(`OBP_LOC_MIN), 32'(`OBP_LOC_MAX));
  endfunction : obp_loc_ok

  always_comb begin
    obp_word_t xlim;
    logic      ok;
    logic      fast;
    xlim = bias_ext_i ? `OBP_XLIM_EXT : `OBP_XLIM_INT;
    ok   = 1'b0;
    fast = s_ff.pbuf ? s_ff.b_fast : s_ff.a_fast;
    nxt_s          = s_ff;
    nxt_s.done     = 1'b0;
    nxt_s.err      = 1'b0;
    nxt_s.rd_valid = 1'b0;
    nxt_s.rd_last  = 1'b0;
    nxt_s.plot_go  = 1'b0;
    nxt_s.grid_go  = 1'b0;
    if (meas_valid_i) begin
      nxt_s.last_rd = meas_data_i;
      nxt_s.rd_ok   = 1'b1;
    end
    if (acq_wr_i && obp_loc_ok(32'(acq_loc_i))) begin
      nxt_s.val_a[acq_loc_i] = 1'b1;
      nxt_s.a_par  = one_shot_i && !s_ff.model;
      nxt_s.a_fast = acq_fast_i;
      nxt_s.a_any  = 1'b1;
      if (!s_ff.a_any || acq_volt_i < s_ff.amin) nxt_s.amin = acq_volt_i;
      if (!s_ff.a_any || acq_volt_i > s_ff.amax) nxt_s.amax = acq_volt_i;
    end
    unique case (s_ff.st)
      OBP_ST_IDLE: begin
        if (lk.cmd_valid) begin
          unique case (lk.cmd_op)
            `OBP_OP_OUT: begin
              ok = (lk.cmd_code <= `OBP_OUT_MAX) && (lk.cmd_nargs == 2'h0 || obp_in(lk.cmd_arg1, 32'sd0, 32'sd1));
              if (lk.cmd_nargs != 2'h0 && lk.cmd_arg1[0] && one_shot_i && s_ff.a_par) ok = 1'b0;
              if (ok) begin
                nxt_s.out_sel = lk.cmd_code[2:0];
                if (lk.cmd_nargs != 2'h0) nxt_s.model = lk.cmd_arg1[0];
                if (lk.cmd_nargs >= 2'h2) nxt_s.ncap = lk.cmd_arg2;
              end
            end
            `OBP_OP_SRC: begin
              ok = (lk.cmd_code <= `OBP_SRC_COPY);
              if (lk.cmd_nargs != 2'h0 && !obp_loc_ok(lk.cmd_arg1)) ok = 1'b0;
              if (lk.cmd_nargs >= 2'h2 && (!obp_loc_ok(lk.cmd_arg2) || lk.cmd_arg2 < lk.cmd_arg1)) ok = 1'b0;
              if (ok && lk.cmd_code == `OBP_SRC_COPY) begin
                nxt_s.st  = OBP_ST_COPY;
                nxt_s.loc = `OBP_LOC_MIN;
                ok        = 1'b0;
              end else if (ok) begin
                nxt_s.src   = obp_src_e'(lk.cmd_code[1:0]);
                nxt_s.first = (lk.cmd_nargs != 2'h0) ? lk.cmd_arg1[8:0] : `OBP_LOC_DEF;
                nxt_s.last  = (lk.cmd_nargs >= 2'h2) ? lk.cmd_arg2[8:0] : `OBP_LOC_MAX;
              end
            end
            `OBP_OP_PLOT: begin
              ok = (lk.cmd_code <= 4'h1) || (lk.cmd_nargs != 2'h0);
              unique case (lk.cmd_code)
                4'h0, 4'h1: begin
                  if (fast && s_ff.ptype != `OBP_PLOT_IDX) ok = 1'b0;
                  nxt_s.plot_pend = ok;
                  nxt_s.plot_go   = ok && !lk.cmd_code[0];
                  nxt_s.grid_go   = ok && lk.cmd_code[0];
                end
                4'h2: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, `OBP_PLOT_MAX);
                  if (fast && lk.cmd_arg1[2:0] != `OBP_PLOT_IDX) ok = 1'b0;
                  if (ok) nxt_s.ptype = lk.cmd_arg1[2:0];
                end
                4'h3: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd1);
                  if (ok) nxt_s.grid = lk.cmd_arg1[0];
                end
                4'h4: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd1);
                  if (ok) nxt_s.pbuf = lk.cmd_arg1[0];
                end
                4'h5: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd2);
                  if (ok) nxt_s.pen = lk.cmd_arg1[1:0];
                end
                4'h6: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd7);
                  if (ok) nxt_s.line = lk.cmd_arg1[2:0];
                end
                4'h7: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd3);
                  if (ok) nxt_s.label = lk.cmd_arg1[1:0];
                end
                4'h8, 4'h9: begin
                  ok = ok && obp_in(lk.cmd_arg1, 32'sd0, 32'sd1);
                  if (lk.cmd_arg1[0]) begin
                    // Limits travel as signed millivolts, so the 1E29 bound can never be exceeded.
                    ok = ok && (lk.cmd_nargs == 2'h3) && (lk.cmd_arg2 <= lk.cmd_arg3);
                    if (lk.cmd_code == 4'h8) begin
                      ok = ok && obp_in(lk.cmd_arg2, -xlim, xlim) && obp_in(lk.cmd_arg3, -xlim, xlim);
                    end
                  end
                  if (ok && lk.cmd_code == 4'h8) begin
                    nxt_s.xprog = lk.cmd_arg1[0];
                    if (lk.cmd_arg1[0]) nxt_s.xmin = lk.cmd_arg2;
                    if (lk.cmd_arg1[0]) nxt_s.xmax = lk.cmd_arg3;
                  end else if (ok) begin
                    nxt_s.yprog = lk.cmd_arg1[0];
                    if (lk.cmd_arg1[0]) nxt_s.ymin = lk.cmd_arg2;
                    if (lk.cmd_arg1[0]) nxt_s.ymax = lk.cmd_arg3;
                  end
                end
                default: ok = 1'b0;
              endcase
            end
            default: ok = 1'b0;
          endcase
          nxt_s.done = ok;
          nxt_s.err  = !ok && (nxt_s.st == OBP_ST_IDLE);
        end else if (lk.talk_req) begin
          if (s_ff.plot_pend) begin
            nxt_s.st      = OBP_ST_TALK;
            nxt_s.from_b  = s_ff.pbuf;
            nxt_s.loc     = `OBP_LOC_DEF;
            nxt_s.end_loc = `OBP_LOC_MAX;
          end else if (s_ff.src == OBP_SRC_NOW) begin
            nxt_s.rd_valid = 1'b1;
            nxt_s.rd_last  = 1'b1;
            nxt_s.rd_data  = s_ff.rd_ok ? s_ff.last_rd : `OBP_NINES;
          end else begin
            nxt_s.st      = OBP_ST_TALK;
            nxt_s.from_b  = (s_ff.src == OBP_SRC_PLOT);
            nxt_s.loc     = s_ff.first;
            nxt_s.end_loc = s_ff.last;
          end
        end
      end
      OBP_ST_TALK: begin
        nxt_s.rd_valid = 1'b1;
        if (s_ff.from_b) nxt_s.rd_data = s_ff.val_b[s_ff.loc] ? mem_b[s_ff.loc] : `OBP_NINES;
        else nxt_s.rd_data = s_ff.val_a[s_ff.loc] ? mem_a[s_ff.loc] : `OBP_NINES;
        nxt_s.loc = s_ff.loc + 9'h001;
        if (s_ff.loc == s_ff.end_loc) begin
          nxt_s.rd_last   = 1'b1;
          nxt_s.plot_pend = 1'b0;
          nxt_s.st        = OBP_ST_IDLE;
        end
      end
      OBP_ST_COPY: begin
        nxt_s.val_b[s_ff.loc] = s_ff.val_a[s_ff.loc];
        nxt_s.loc = s_ff.loc + 9'h001;
        if (s_ff.loc == `OBP_LOC_MAX) begin
          nxt_s.st     = OBP_ST_IDLE;
          nxt_s.done   = 1'b1;
          nxt_s.bmin   = s_ff.amin;
          nxt_s.bmax   = s_ff.amax;
          nxt_s.b_fast = s_ff.a_fast;
        end
      end
      default: nxt_s.st = OBP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff       <= '0;
      s_ff.first <= `OBP_LOC_DEF;
      s_ff.last  <= `OBP_LOC_MAX;
      s_ff.pen   <= `OBP_PEN_DEF;
      s_ff.line  <= `OBP_LINE_DEF;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // The arrays carry no reset; the valid vectors decide what is ever sent.
  always_ff @(posedge core_clk_i) begin
    if (acq_wr_i && obp_loc_ok(32'(acq_loc_i))) mem_a[acq_loc_i] <= acq_data_i;
    if (s_ff.st == OBP_ST_COPY) mem_b[s_ff.loc] <= mem_a[s_ff.loc];
  end

  assign lk.cmd_done  = s_ff.done;
  assign lk.cmd_err   = s_ff.err;
  assign lk.rd_valid  = s_ff.rd_valid;
  assign lk.rd_data   = s_ff.rd_data;
  assign lk.rd_last   = s_ff.rd_last;
  assign out_sel_o    = s_ff.out_sel;
  assign model_o      = s_ff.model;
  assign normalising_capacitance_o = s_ff.ncap;
  assign src_o        = s_ff.src;
  assign plot_type_o  = s_ff.ptype;
  assign grid_o       = s_ff.grid;
  assign plot_buf_o   = s_ff.pbuf;
  assign pen_o        = s_ff.pen;
  assign line_o       = s_ff.line;
  assign label_o      = s_ff.label;
  assign x_min_o      = s_ff.xprog ? s_ff.xmin : (s_ff.pbuf ? s_ff.bmin : s_ff.amin);
  assign x_max_o      = s_ff.xprog ? s_ff.xmax : (s_ff.pbuf ? s_ff.bmax : s_ff.amax);
  assign y_min_o      = s_ff.yprog ? s_ff.ymin : ((s_ff.ptype == `OBP_PLOT_DIFF) ? -full_scale_i : '0);
  assign y_max_o      = s_ff.yprog ? s_ff.ymax : full_scale_i;
  assign plot_go_o    = s_ff.plot_go;
  assign grid_go_o    = s_ff.grid_go;
  assign busy_o       = (s_ff.st != OBP_ST_IDLE);
endmodule : obp_device
`default_nettype wire

/* hdl/obp_consts.svh */
// Notes on behaviour
// - Reset output selection: triple data, parallel, zero.
// - One-shot parallel data never converts to series; the device refuses the change only while one_shot_i is still high.
// - Source codes: now, acquisition, plot, copy.
// - First and last locations lie in 1..450.
// - Data source resets to current reading.
// - Current reading comes from last-reading register.
// - Acquisition buffer invalid until sweep; send nines.
// - Plot buffer holds nines until copied.
// - Default buffer span is 4 to 450.
// - Option 0 plots, 1 grids, others set.
// - Plot type accepts codes 0 to 6.
// - Grid type: 0 full, 1 axes only.
// - Plot buffer: 0 acquisition, 1 plot.
// - Pen 0..2, line type 0..7.
// - Label type accepts codes 0 to 3.
// - X autoscale to buffer voltages, or programmed.
// - Y autoscale zero or plus-minus full scale.
// - X limits 20 internal, 200 external bias.
// - Controller supplies parameter for options 2..7.
// - Plot defaults zero, pen 1, solid line.
// - Controller addresses talk and listen after plot.
// - Fastest-rate data plots only against index.
`ifndef OBP_CONSTS_SVH
`define OBP_CONSTS_SVH
`define OBP_OP_OUT     2'h0
`define OBP_OP_SRC     2'h1
`define OBP_OP_PLOT    2'h2
`define OBP_LOC_MIN    9'h001
`define OBP_LOC_MAX    9'h1c2
`define OBP_LOC_DEF    9'h004
`define OBP_NINES      32'h9999_9999
`define OBP_OUT_MAX    4'h7
`define OBP_SRC_COPY   4'h3
`define OBP_PLOT_MAX   32'h0000_0006
`define OBP_PLOT_IDX   3'h4
`define OBP_PLOT_DIFF  3'h5
`define OBP_PEN_DEF    2'h1
`define OBP_LINE_DEF   3'h7
`define OBP_XLIM_INT   32'h0000_4e20
`define OBP_XLIM_EXT   32'h0003_0d40
`define OBP_REG_CMD    8'h00
`define OBP_REG_ARG1   8'h04
`define OBP_REG_ARG2   8'h08
`define OBP_REG_ARG3   8'h0c
`define OBP_REG_STAT   8'h10
`define OBP_REG_RXD    8'h14
`define OBP_REG_RXCNT  8'h18
`define OBP_REG_TALK   8'h1c
`endif

/* hdl/obp_pkg.sv */
package obp_pkg;
  typedef logic signed [31:0] obp_word_t;
  typedef enum logic [1:0] {
    OBP_SRC_NOW  = 2'h0,
    OBP_SRC_ACQ  = 2'h1,
    OBP_SRC_PLOT = 2'h2
  } obp_src_e;
  typedef enum logic [1:0] {
    OBP_ST_IDLE = 2'b00,
    OBP_ST_TALK = 2'b01,
    OBP_ST_COPY = 2'b11
  } obp_state_e;
endpackage : obp_pkg

/* hdl/obp_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface obp_link_if;
  import obp_pkg::*;
  logic            cmd_valid;
  logic [1:0]      cmd_op;
  logic [3:0]      cmd_code;
  logic [1:0]      cmd_nargs;
  obp_word_t       cmd_arg1;
  obp_word_t       cmd_arg2;
  obp_word_t       cmd_arg3;
  logic            cmd_done;
  logic            cmd_err;
  logic            talk_req;
  logic            rd_valid;
  logic [31:0]     rd_data;
  logic            rd_last;
  modport dev (input cmd_valid, cmd_op, cmd_code, cmd_nargs, cmd_arg1, cmd_arg2, cmd_arg3, talk_req,
               output cmd_done, cmd_err, rd_valid, rd_data, rd_last);
  modport ctl (output cmd_valid, cmd_op, cmd_code, cmd_nargs, cmd_arg1, cmd_arg2, cmd_arg3, talk_req,
               input cmd_done, cmd_err, rd_valid, rd_data, rd_last);
endinterface : obp_link_if
`default_nettype wire

/* hdl/obp_controller.sv */
`timescale 1ns/10ps
`default_nettype none
`include "obp_consts.svh"
module obp_controller
  import obp_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Software register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // Plotter listening on the link.
  output logic             plot_valid_o,
  output logic [31:0]      plot_data_o,
  output logic             plot_last_o,
  // Link to the device.
  obp_link_if.ctl          lk
);
  typedef struct packed {
    logic        cmd_valid;
    logic [1:0]  op;
    logic [3:0]  code;
    logic [1:0]  nargs;
    obp_word_t   a1;
    obp_word_t   a2;
    obp_word_t   a3;
    logic        busy;
    logic        auto_talk;
    logic        talk_req;
    logic        listen;
    logic        err;
    logic [31:0] rx_data;
    logic [9:0]  rx_cnt;
    logic [31:0] rdata;
    logic        pv;
    logic [31:0] pd;
    logic        pl;
  } obp_ctl_s;

  obp_ctl_s s_ff;
  obp_ctl_s nxt_s;

  always_comb begin
    nxt_s           = s_ff;
    nxt_s.cmd_valid = 1'b0;
    nxt_s.talk_req  = 1'b0;
    nxt_s.pv        = 1'b0;
    nxt_s.pl        = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        `OBP_REG_ARG1: nxt_s.a1 = wdata_i;
        `OBP_REG_ARG2: nxt_s.a2 = wdata_i;
        `OBP_REG_ARG3: nxt_s.a3 = wdata_i;
        `OBP_REG_STAT: if (wdata_i[0]) nxt_s.err = 1'b0;
        `OBP_REG_TALK: if (!s_ff.busy) begin
          nxt_s.talk_req = 1'b1;
          nxt_s.busy     = 1'b1;
        end
        `OBP_REG_CMD: if (!s_ff.busy) begin
          // A short plotter option would only be refused by the device for its missing parameter.
          if (wdata_i[1:0] == `OBP_OP_PLOT && wdata_i[7:4] >= 4'h2 && wdata_i[7:4] <= 4'h7 &&
              wdata_i[9:8] == 2'h0) begin
            nxt_s.err = 1'b1;
          end else begin
            nxt_s.cmd_valid = 1'b1;
            nxt_s.op        = wdata_i[1:0];
            nxt_s.code      = wdata_i[7:4];
            nxt_s.nargs     = wdata_i[9:8];
            nxt_s.busy      = 1'b1;
            nxt_s.auto_talk = (wdata_i[1:0] == `OBP_OP_PLOT) && (wdata_i[7:4] <= 4'h1);
          end
        end
        default: ;
      endcase
    end
    if (lk.cmd_done) begin
      nxt_s.busy = s_ff.auto_talk;
      if (s_ff.auto_talk) begin
        nxt_s.talk_req  = 1'b1;
        nxt_s.listen    = 1'b1;
        nxt_s.auto_talk = 1'b0;
      end
    end
    if (lk.cmd_err) begin
      nxt_s.busy      = 1'b0;
      nxt_s.auto_talk = 1'b0;
      nxt_s.err       = 1'b1;
    end
    if (lk.rd_valid) begin
      nxt_s.rx_data = lk.rd_data;
      nxt_s.rx_cnt  = s_ff.rx_cnt + 10'h001;
      nxt_s.pv      = s_ff.listen;
      nxt_s.pd      = lk.rd_data;
      nxt_s.pl      = s_ff.listen && lk.rd_last;
      if (lk.rd_last) begin
        nxt_s.busy   = 1'b0;
        nxt_s.listen = 1'b0;
      end
    end
    nxt_s.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        `OBP_REG_ARG1:  nxt_s.rdata = s_ff.a1;
        `OBP_REG_ARG2:  nxt_s.rdata = s_ff.a2;
        `OBP_REG_ARG3:  nxt_s.rdata = s_ff.a3;
        `OBP_REG_STAT:  nxt_s.rdata = {29'h0, s_ff.listen, s_ff.busy, s_ff.err};
        `OBP_REG_RXD:   nxt_s.rdata = s_ff.rx_data;
        `OBP_REG_RXCNT: nxt_s.rdata = {22'h0, s_ff.rx_cnt};
        default:        nxt_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  assign lk.cmd_valid = s_ff.cmd_valid;
  assign lk.cmd_op    = s_ff.op;
  assign lk.cmd_code  = s_ff.code;
  assign lk.cmd_nargs = s_ff.nargs;
  assign lk.cmd_arg1  = s_ff.a1;
  assign lk.cmd_arg2  = s_ff.a2;
  assign lk.cmd_arg3  = s_ff.a3;
  assign lk.talk_req  = s_ff.talk_req;
  assign rdata_o      = s_ff.rdata;
  assign plot_valid_o = s_ff.pv;
  assign plot_data_o  = s_ff.pd;
  assign plot_last_o  = s_ff.pl;
endmodule : obp_controller
`default_nettype wire

/* dv/obp_link_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module obp_link_chk
  import obp_pkg::*;
(
  // Clock and reset.
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  // Link signals.
  input wire logic       cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] cmd_code,
  input wire logic [1:0] cmd_nargs,
  input wire obp_word_t  cmd_arg1,
  input wire obp_word_t  cmd_arg2,
  input wire logic       cmd_done,
  input wire logic       cmd_err,
  input wire logic       talk_req,
  input wire logic       rd_last
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic is_a;
  assign is_a = cmd_valid && cmd_op == 2'h2 && cmd_nargs != 2'h0;
  property p_answer; cmd_valid && !(cmd_op == 2'h1 && cmd_code == 4'h3) |=> cmd_done ^ cmd_err; endproperty
  a_answer: assert property (p_answer) else $error("command not answered once");
  property p_copy; cmd_valid && cmd_op == 2'h1 && cmd_code == 4'h3 && cmd_nargs == 2'h0 |-> ##[451:451] cmd_done; endproperty
  a_copy: assert property (p_copy) else $error("copy done at wrong time");
  property p_loc; cmd_valid && cmd_op == 2'h1 && (cmd_code == 4'h1 || cmd_code == 4'h2) && cmd_nargs != 2'h0
    && (cmd_arg1 < 32'sh1 || cmd_arg1 > 32'sh1c2) |=> cmd_err; endproperty
  a_loc: assert property (p_loc) else $error("bad location accepted");
  property p_code; cmd_valid && cmd_op == 2'h1 && cmd_code > 4'h3 |=> cmd_err && !cmd_done; endproperty
  a_code: assert property (p_code) else $error("bad source code accepted");
  property p_type; is_a && cmd_code == 4'h2 && cmd_arg1 > 32'sh6 |=> cmd_err; endproperty
  a_type: assert property (p_type) else $error("bad plot type accepted");
  property p_grid; is_a && (cmd_code == 4'h3 || cmd_code == 4'h4) && cmd_arg1 > 32'sh1 |=> cmd_err; endproperty
  a_grid: assert property (p_grid) else $error("bad grid or buffer accepted");
  property p_pen; is_a && ((cmd_code == 4'h5 && cmd_arg1 > 32'sh2) || (cmd_code == 4'h6 && cmd_arg1 > 32'sh7))
    |=> cmd_err; endproperty
  a_pen: assert property (p_pen) else $error("bad pen or line accepted");
  property p_label; is_a && cmd_code == 4'h7 && cmd_arg1 > 32'sh3 |=> cmd_err; endproperty
  a_label: assert property (p_label) else $error("bad label accepted");
  property p_narg; cmd_valid && cmd_op == 2'h2 && cmd_code >= 4'h2 && cmd_code <= 4'h7 |-> cmd_nargs != 2'h0; endproperty
  a_narg: assert property (p_narg) else $error("plotter option sent bare");
  property p_talk; talk_req |-> ##[1:452] rd_last; endproperty
  a_talk: assert property (p_talk) else $error("talk never ended");
  property p_xlim; is_a && cmd_code == 4'h8 && cmd_arg1 == 32'sh1
    && (cmd_arg2 > 32'sh30d40 || cmd_arg2 < -32'sh30d40) |=> cmd_err; endproperty
  a_xlim: assert property (p_xlim) else $error("x limit out of span accepted");
endmodule : obp_link_chk
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "obp_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top
  import obp_pkg::*;
;
  logic             core_clk_i, resetn_i, meas_valid_i, acq_wr_i, acq_fast_i, one_shot_i, bias_ext_i;
  logic             wr_i, rd_i, model_o, grid_o, plot_buf_o, plot_go_o, grid_go_o, busy_o;
  logic             plot_valid_o, plot_last_o;
  logic [1:0]       src_o, pen_o, label_o;
  logic [2:0]       out_sel_o, plot_type_o, line_o;
  logic [7:0]       addr_i;
  logic [8:0]       acq_loc_i;
  logic [31:0]      meas_data_i, acq_data_i, wdata_i, rdata_o, plot_data_o, plot_word, v;
  obp_word_t        acq_volt_i, full_scale_i, normalising_capacitance_o, x_min_o, x_max_o, y_min_o, y_max_o;
  logic [31:0]      pmax [2:7] = '{32'h6, 32'h1, 32'h1, 32'h2, 32'h7, 32'h3};
  int               n_errors, n_compared, n_plot, n_pgo, n_ggo, n_plast;
  obp_link_if link ();
  obp_device i_obp_device (.lk(link), .*);
  obp_controller i_obp_controller (.lk(link), .*);
  obp_link_chk i_obp_link_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .cmd_code(link.cmd_code), .cmd_nargs(link.cmd_nargs), .cmd_arg1(link.cmd_arg1),
    .cmd_arg2(link.cmd_arg2), .cmd_done(link.cmd_done), .cmd_err(link.cmd_err), .talk_req(link.talk_req),
    .rd_last(link.rd_last));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (plot_valid_o === 1'b1) begin
      n_plot++;
      plot_word = plot_data_o;
    end
    if (plot_go_o === 1'b1) n_pgo++;
    if (grid_go_o === 1'b1) n_ggo++;
    if (plot_last_o === 1'b1) n_plast++;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask : rd
  task wait_idle(output logic [31:0] st);
    int i;
    i  = 0;
    st = 32'h2;
    while (st[1] !== 1'b0 && i < 1000) begin
      rd(`OBP_REG_STAT, st);
      i++;
    end
    `CHK("busy", 1'b0, st[1])
  endtask : wait_idle
  task do_cmd(input logic [1:0] op, input logic [3:0] c, input logic [1:0] na, input obp_word_t a1, a2, a3,
              input logic ee);
    logic [31:0] st;
    wr(`OBP_REG_ARG1, a1);
    wr(`OBP_REG_ARG2, a2);
    wr(`OBP_REG_ARG3, a3);
    wr(`OBP_REG_CMD, {22'h0, na, c, 2'h0, op});
    wait_idle(st);
    `CHK("err", ee, st[0])
    if (st[0] === 1'b1) wr(`OBP_REG_STAT, 32'h1);
  endtask : do_cmd
  task talk(input logic [9:0] n, input logic [31:0] w);
    logic [31:0] c0;
    rd(`OBP_REG_RXCNT, c0);
    wr(`OBP_REG_TALK, 32'h1);
    wait_idle(v);
    rd(`OBP_REG_RXCNT, v);
    `CHK("words", n, v[9:0] - c0[9:0])
    rd(`OBP_REG_RXD, v);
    `CHK("last word", w, v)
  endtask : talk
  task acq(input logic [8:0] l, input logic [31:0] d, input obp_word_t u);
    @(posedge core_clk_i);
    acq_wr_i   <= 1'b1;
    acq_loc_i  <= l;
    acq_data_i <= d;
    acq_volt_i <= u;
    @(posedge core_clk_i);
    acq_wr_i <= 1'b0;
  endtask : acq
  function automatic logic [31:0] par(input int c);
    case (c)
      2: par = {29'h0, plot_type_o};
      3: par = {31'h0, grid_o};
      4: par = {31'h0, plot_buf_o};
      5: par = {30'h0, pen_o};
      6: par = {29'h0, line_o};
      default: par = {30'h0, label_o};
    endcase
  endfunction : par
  task endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    #900000;
    n_errors++;
    $display("BAD watchdog exp end got hang");
    test_done;
  end
  initial begin
    {resetn_i, meas_valid_i, acq_wr_i, acq_fast_i, one_shot_i, bias_ext_i, wr_i, rd_i} = 8'h0;
    {addr_i, acq_loc_i, meas_data_i, acq_data_i, wdata_i} = '0;
    acq_volt_i   = 32'sh0;
    full_scale_i = 32'sh1388;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    `CHK("defaults", 7'h04, {out_sel_o, model_o, normalising_capacitance_o == 0, src_o})
    `CHK("plot defaults", 12'h03c, {plot_type_o, grid_o, plot_buf_o, pen_o, line_o, label_o})
    rd(8'h20, v);
    `CHK("unmapped", 32'h0, v)
    do_cmd(2'h0, 4'h3, 2'h2, 32'sh1, 32'sh5, 32'sh0, 1'b0);
    `CHK("output", 36'h7_0000_0005, {out_sel_o, model_o, normalising_capacitance_o})
    do_cmd(2'h0, 4'h8, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b1);
    do_cmd(2'h0, 4'h0, 2'h2, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    endt("output");
    talk(10'h1, `OBP_NINES);
    @(posedge core_clk_i);
    meas_valid_i <= 1'b1;
    meas_data_i  <= 32'h1234_5678;
    @(posedge core_clk_i);
    meas_valid_i <= 1'b0;
    talk(10'h1, 32'h1234_5678);
    endt("current");
    do_cmd(2'h1, 4'h1, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    talk(10'h1bf, `OBP_NINES);
    acq(9'h1c2, 32'h0000_abcd, -32'sh12c);
    acq(9'h00a, 32'h0000_0022, 32'sh1f4);
    talk(10'h1bf, 32'h0000_abcd);
    do_cmd(2'h1, 4'h1, 2'h2, 32'sh64, 32'shc8, 32'sh0, 1'b0);
    talk(10'h65, `OBP_NINES);
    do_cmd(2'h1, 4'h1, 2'h1, 32'sh1c3, 32'sh0, 32'sh0, 1'b1);
    do_cmd(2'h1, 4'h1, 2'h1, 32'sh0, 32'sh0, 32'sh0, 1'b1);
    do_cmd(2'h1, 4'h1, 2'h2, 32'shc8, 32'sh64, 32'sh0, 1'b1);
    do_cmd(2'h1, 4'h4, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b1);
    `CHK("source", 2'h1, src_o)
    do_cmd(2'h1, 4'h2, 2'h1, 32'sh1c2, 32'sh0, 32'sh0, 1'b0);
    talk(10'h1, `OBP_NINES);
    do_cmd(2'h1, 4'h3, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("source", 3'h2, {busy_o, src_o})
    talk(10'h1, 32'h0000_abcd);
    do_cmd(2'h1, 4'h0, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("source", 2'h0, src_o)
    endt("source");
    for (int c = 2; c < 8; c++) begin
      do_cmd(2'h2, c[3:0], 2'h1, pmax[c], 32'sh0, 32'sh0, 1'b0);
      do_cmd(2'h2, c[3:0], 2'h1, pmax[c] + 32'h1, 32'sh0, 32'sh0, 1'b1);
      `CHK("param", pmax[c], par(c))
    end
    do_cmd(2'h2, 4'h5, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b1);
    do_cmd(2'h2, 4'h4, 2'h1, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    do_cmd(2'h2, 4'h8, 2'h1, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("x auto", {-32'sh12c, 32'sh1f4}, {x_min_o, x_max_o})
    do_cmd(2'h2, 4'h8, 2'h3, 32'sh1, -32'sh4e20, 32'sh4e20, 1'b0);
    `CHK("x lim", {-32'sh4e20, 32'sh4e20}, {x_min_o, x_max_o})
    do_cmd(2'h2, 4'h8, 2'h3, 32'sh1, 32'sh0, 32'sh4e21, 1'b1);
    bias_ext_i <= 1'b1;
    do_cmd(2'h2, 4'h8, 2'h3, 32'sh1, -32'sh30d40, 32'sh30d40, 1'b0);
    do_cmd(2'h2, 4'h8, 2'h3, 32'sh1, -32'sh30d41, 32'sh0, 1'b1);
    do_cmd(2'h2, 4'h9, 2'h1, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("y auto", {32'sh0, 32'sh1388}, {y_min_o, y_max_o})
    do_cmd(2'h2, 4'h2, 2'h1, 32'sh5, 32'sh0, 32'sh0, 1'b0);
    `CHK("y diff", -32'sh1388, y_min_o)
    endt("plot params");
    do_cmd(2'h2, 4'h0, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("plot", {32'h1, 32'h1bf, 32'h0000_abcd}, {n_pgo, n_plot, plot_word})
    do_cmd(2'h2, 4'h1, 2'h0, 32'sh0, 32'sh0, 32'sh0, 1'b0);
    `CHK("grid", {32'h1, 32'h37e, 32'h2}, {n_ggo, n_plot, n_plast})
    endt("plot run");
    acq_fast_i <= 1'b1;
    acq(9'h005, 32'h0000_0033, 32'sh0);
    do_cmd(2'h2, 4'h2, 2'h1, 32'sh0, 32'sh0, 32'sh0, 1'b1);
    do_cmd(2'h2, 4'h2, 2'h1, 32'sh4, 32'sh0, 32'sh0, 1'b0);
    acq_fast_i <= 1'b0;
    one_shot_i <= 1'b1;
    acq(9'h006, 32'h0000_0044, 32'sh0);
    do_cmd(2'h0, 4'h0, 2'h1, 32'sh1, 32'sh0, 32'sh0, 1'b1);
    `CHK("model", 1'b0, model_o)
    endt("restrictions");
    test_done;
  end
endmodule : tb_top
`default_nettype wire
